// *** src/pfip_params.svh ***
// Constants for the parallel and fixed input port block
`ifndef PFIP_PARAMS_SVH
`define PFIP_PARAMS_SVH
`define PFIP_WIDTH 8
`define PFIP_NPORTS 3
`define PFIP_DIR_RST 8'h00
`define PFIP_LATCH_RST 8'h00
`define PFIP_FIX_MASK 8'hbf
`define PFIP_RX_BIT 0
`define PFIP_TX_BIT 1
`define PFIP_MISO_BIT 2
`define PFIP_MOSI_BIT 3
`define PFIP_SCK_BIT 4
`define PFIP_SS_BIT 5
`define PFIP_NOPIN_BIT 6
`endif

// *** src/pfip_pkg.sv ***
// Types shared by the port block
package pfip_pkg;
	typedef struct packed {
		logic rx_on;
		logic tx_on;
		logic sync_serial_on;
	} pfip_serial_t;
	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe_n;
	} pfip_pin_t;
	typedef enum logic [1:0] {
		PFIP_SEL_A,
		PFIP_SEL_B,
		PFIP_SEL_C,
		PFIP_SEL_D
	} pfip_sel_t;
endpackage

// *** src/pfip_ports.sv ***
// Three bidirectional ports and the fixed input port
//
// Overview of operation
// - Direction bit one: pin driven as output.
// - Direction bit zero: pin left undriven as input.
// - One 8-bit direction register per bidirectional port, bit per pin.
// - Reset clears all direction registers, all pins inputs.
// - Direction registers are writable and readable in full.
// - Output bit reads return the output latch, not the pin.
// - Data write to input bit updates latch, pin stays undriven.
// - Data write to output bit updates latch and drives pin at once.
// - Input bit reads return the pin level.
// - Fixed port: 7 input lines 0-5 and 7, sampled continuously.
// - Reset disables serial drivers; all fixed bits read as inputs.
// - Async receiver and transmitter both on: fixed bits 0,1 read zero.
// - Sync serial off: fixed bits 2-5 read sampled pin levels.
// - Fixed port has no output latch or writable data register.
// - Async serial uses fixed bit 0 receive, bit 1 transmit.
// - Sync serial uses fixed bits 2-5 as MISO, MOSI, SCK, SS.
// - Enabled serial blocks take precedence on shared fixed lines.
`timescale 1ns/100ps
`include "pfip_params.svh"
module pfip_ports #(
	parameter int W = `PFIP_WIDTH
) (
	input wire logic mclk,
	input wire logic rst,
	input wire pfip_pkg::pfip_sel_t sel,
	input wire logic wr_data,
	input wire logic wr_dir,
	input wire logic rd,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] rdata_q,
	input wire logic [W-1:0] pa_i,
	input wire logic [W-1:0] pb_i,
	input wire logic [W-1:0] pc_i,
	output pfip_pkg::pfip_pin_t pa_q,
	output pfip_pkg::pfip_pin_t pb_q,
	output pfip_pkg::pfip_pin_t pc_q,
	input wire logic [W-1:0] fixed_input_lines,
	input wire pfip_pkg::pfip_serial_t serial_en,
	input wire logic async_tx_data,
	input wire logic async_tx_oe,
	input wire logic [3:0] sync_out_data,
	input wire logic [3:0] sync_out_oe,
	output logic async_rx_line_q,
	output logic [3:0] sync_in_q,
	output pfip_pkg::pfip_pin_t pd_q
);
	logic [W-1:0] dir_q [3];
	logic [W-1:0] lat_q [3];
	logic [W-1:0] meta_q [4];
	logic [W-1:0] sync_q [4];
	logic [W-1:0] rd_d;
	logic [W-1:0] fix_v;
	logic [1:0] idx;

	assign idx = sel[1:0];

	// Two stages; the first stage feeds only the second
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				meta_q[i] <= '0;
				sync_q[i] <= '0;
			end
		end else begin
			meta_q[0] <= pa_i;
			meta_q[1] <= pb_i;
			meta_q[2] <= pc_i;
			meta_q[3] <= fixed_input_lines;
			for (int i = 0; i < 4; i++)
				sync_q[i] <= meta_q[i];
		end
	end

	// Direction and latch storage; fixed port has neither
	// A read-back strobe shares wr_dir, so it must never write
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 3; i++) begin
				dir_q[i] <= `PFIP_DIR_RST;
				lat_q[i] <= `PFIP_LATCH_RST;
			end
		end else if (sel != pfip_pkg::PFIP_SEL_D) begin
			if (wr_dir && !rd)
				dir_q[idx] <= wdata;
			if (wr_data)
				lat_q[idx] <= wdata;
		end
	end

	// Pin drive registered from the next latch and direction values
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pa_q <= '{o: '0, oe_n: '1};
			pb_q <= '{o: '0, oe_n: '1};
			pc_q <= '{o: '0, oe_n: '1};
		end else begin
			pa_q <= '{o: nxt_lat(0), oe_n: ~nxt_dir(0)};
			pb_q <= '{o: nxt_lat(1), oe_n: ~nxt_dir(1)};
			pc_q <= '{o: nxt_lat(2), oe_n: ~nxt_dir(2)};
		end
	end

	// Pin follows a write on the same edge the latch takes it
	function automatic logic [W-1:0] nxt_lat(input int p);
		if (wr_data && idx == p[1:0] && sel != pfip_pkg::PFIP_SEL_D)
			return wdata;
		return lat_q[p];
	endfunction

	function automatic logic [W-1:0] nxt_dir(input int p);
		if (wr_dir && !rd && idx == p[1:0] &&
			sel != pfip_pkg::PFIP_SEL_D)
			return wdata;
		return dir_q[p];
	endfunction

	// Fixed port view with serial blocks taking their lines
	always_comb begin
		fix_v = sync_q[3] & `PFIP_FIX_MASK;
		if (serial_en.rx_on && serial_en.tx_on) begin
			fix_v[`PFIP_RX_BIT] = 1'b0;
			fix_v[`PFIP_TX_BIT] = 1'b0;
		end
		if (serial_en.sync_serial_on)
			fix_v[`PFIP_SS_BIT:`PFIP_MISO_BIT] = 4'h0;
	end

	always_comb begin
		rd_d = rdata_q;
		if (rd) begin
			unique case (sel)
				pfip_pkg::PFIP_SEL_A, pfip_pkg::PFIP_SEL_B,
				pfip_pkg::PFIP_SEL_C: begin
					if (wr_dir)
						rd_d = dir_q[idx];
					else
						rd_d = (lat_q[idx] & dir_q[idx]) |
							(sync_q[idx] & ~dir_q[idx]);
				end
				pfip_pkg::PFIP_SEL_D: rd_d = fix_v;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			rdata_q <= '0;
		else
			rdata_q <= rd_d;
	end

	// Serial peripherals see the synchronised lines
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			async_rx_line_q <= 1'b0;
			sync_in_q <= 4'h0;
		end else begin
			async_rx_line_q <= sync_q[3][`PFIP_RX_BIT];
			sync_in_q <= sync_q[3][`PFIP_SS_BIT:`PFIP_MISO_BIT];
		end
	end

	// Reset leaves every fixed line undriven
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pd_q <= '{o: '0, oe_n: '1};
		end else begin
			pd_q.o <= '0;
			pd_q.oe_n <= '1;
			if (serial_en.tx_on && async_tx_oe) begin
				pd_q.o[`PFIP_TX_BIT] <= async_tx_data;
				pd_q.oe_n[`PFIP_TX_BIT] <= 1'b0;
			end
			if (serial_en.sync_serial_on) begin
				pd_q.o[`PFIP_SS_BIT:`PFIP_MISO_BIT] <= sync_out_data;
				pd_q.oe_n[`PFIP_SS_BIT:`PFIP_MISO_BIT] <= ~sync_out_oe;
			end
		end
	end

	a_dir_reset: assert property (@(posedge mclk)
		$fell(rst) |-> pa_q.oe_n == 8'hff && pb_q.oe_n == 8'hff &&
		pc_q.oe_n == 8'hff) else $error("pins driven after reset");
	a_pin_drive: assert property (@(posedge mclk) disable iff (rst)
		##1 pa_q.oe_n == ~dir_q[0] && pb_q.oe_n == ~dir_q[1])
		else $error("drive does not follow direction");
	a_pin_float: assert property (@(posedge mclk) disable iff (rst)
		##1 ((pc_q.oe_n | dir_q[2]) == 8'hff))
		else $error("input pin driven");
	a_write_drive: assert property (@(posedge mclk) disable iff (rst)
		wr_data && sel == pfip_pkg::PFIP_SEL_A && !wr_dir
		|=> pa_q.o == $past(wdata))
		else $error("write not driven next cycle");
	a_dir_rdback: assert property (@(posedge mclk) disable iff (rst)
		rd && wr_dir && sel == pfip_pkg::PFIP_SEL_B
		|=> rdata_q == $past(dir_q[1]))
		else $error("direction read wrong");
	a_data_read: assert property (@(posedge mclk) disable iff (rst)
		rd && !wr_dir && sel == pfip_pkg::PFIP_SEL_A
		|=> rdata_q == (($past(lat_q[0]) & $past(dir_q[0])) |
		($past(sync_q[0]) & ~$past(dir_q[0]))))
		else $error("data read mux wrong");
	a_fix_bit6: assert property (@(posedge mclk) disable iff (rst)
		rd && sel == pfip_pkg::PFIP_SEL_D |=> rdata_q[6] == 1'b0)
		else $error("fixed bit 6 not zero");
	a_fix_async: assert property (@(posedge mclk) disable iff (rst)
		rd && sel == pfip_pkg::PFIP_SEL_D && serial_en.rx_on &&
		serial_en.tx_on |=> rdata_q[1:0] == 2'h0)
		else $error("async lines not zero");
	a_fix_sync: assert property (@(posedge mclk) disable iff (rst)
		rd && sel == pfip_pkg::PFIP_SEL_D && !serial_en.sync_serial_on
		|=> rdata_q[5:2] == $past(sync_q[3][5:2]))
		else $error("sync lines not pin level");

	// Read-back must leave the direction registers untouched
	a_dir_keep: assert property (@(posedge mclk) disable iff (rst)
		rd && wr_dir |=> dir_q[0] == $past(dir_q[0]) &&
		dir_q[1] == $past(dir_q[1]) && dir_q[2] == $past(dir_q[2]))
		else $error("direction changed by read-back");

	a_dir_write_a: assert property (@(posedge mclk) disable iff (rst)
		wr_dir && !rd && sel == pfip_pkg::PFIP_SEL_A
		|=> dir_q[0] == $past(wdata))
		else $error("direction A not written");

	a_dir_write_c: assert property (@(posedge mclk) disable iff (rst)
		wr_dir && !rd && sel == pfip_pkg::PFIP_SEL_C
		|=> dir_q[2] == $past(wdata))
		else $error("direction C not written");

	a_dir_rdback_a: assert property (@(posedge mclk) disable iff (rst)
		rd && wr_dir && sel == pfip_pkg::PFIP_SEL_A
		|=> rdata_q == $past(dir_q[0]))
		else $error("direction A read wrong");

	a_dir_rdback_c: assert property (@(posedge mclk) disable iff (rst)
		rd && wr_dir && sel == pfip_pkg::PFIP_SEL_C
		|=> rdata_q == $past(dir_q[2]))
		else $error("direction C read wrong");

	// Fixed port selection must never reach the latches
	a_lat_fixed: assert property (@(posedge mclk) disable iff (rst)
		wr_data && sel == pfip_pkg::PFIP_SEL_D
		|=> lat_q[0] == $past(lat_q[0]) && lat_q[1] == $past(lat_q[1])
		&& lat_q[2] == $past(lat_q[2]))
		else $error("fixed port write reached a latch");

	a_write_b: assert property (@(posedge mclk) disable iff (rst)
		wr_data && sel == pfip_pkg::PFIP_SEL_B
		|=> lat_q[1] == $past(wdata) && pb_q.o == $past(wdata))
		else $error("latch B not written");

	a_write_c: assert property (@(posedge mclk) disable iff (rst)
		wr_data && sel == pfip_pkg::PFIP_SEL_C && !wr_dir
		|=> pc_q.o == $past(wdata))
		else $error("latch C not driven next cycle");

	a_drive_c: assert property (@(posedge mclk) disable iff (rst)
		pc_q.oe_n == ~dir_q[2])
		else $error("drive C does not follow direction");

	a_float_a: assert property (@(posedge mclk) disable iff (rst)
		(pa_q.oe_n | dir_q[0]) == 8'hff)
		else $error("input pin A driven");

	a_float_b: assert property (@(posedge mclk) disable iff (rst)
		(pb_q.oe_n | dir_q[1]) == 8'hff)
		else $error("input pin B driven");

	a_data_read_b: assert property (@(posedge mclk) disable iff (rst)
		rd && !wr_dir && sel == pfip_pkg::PFIP_SEL_B
		|=> rdata_q == (($past(lat_q[1]) & $past(dir_q[1])) |
		($past(sync_q[1]) & ~$past(dir_q[1]))))
		else $error("data read B wrong");

	a_data_read_c: assert property (@(posedge mclk) disable iff (rst)
		rd && !wr_dir && sel == pfip_pkg::PFIP_SEL_C
		|=> rdata_q == (($past(lat_q[2]) & $past(dir_q[2])) |
		($past(sync_q[2]) & ~$past(dir_q[2]))))
		else $error("data read C wrong");

	// Read data stands until the next read request
	a_read_hold: assert property (@(posedge mclk) disable iff (rst)
		!rd |=> $stable(rdata_q))
		else $error("read data changed without a read");

	// Pin levels reach the read path after exactly two stages
	a_pin_two_ff: assert property (@(posedge mclk) disable iff (rst)
		1'b1 |=> ##1 sync_q[0] == $past(pa_i, 2))
		else $error("pin A not two stages deep");

	a_rx_path: assert property (@(posedge mclk) disable iff (rst)
		1'b1 |=> async_rx_line_q == $past(sync_q[3][`PFIP_RX_BIT]))
		else $error("receive line not passed on");

	a_sync_path: assert property (@(posedge mclk) disable iff (rst)
		1'b1 |=> sync_in_q == $past(sync_q[3][5:2]))
		else $error("sync serial lines not passed on");

	// With both serial blocks off no fixed line may be driven
	a_pd_idle: assert property (@(posedge mclk) disable iff (rst)
		!serial_en.tx_on && !serial_en.sync_serial_on
		|=> pd_q.oe_n == 8'hff)
		else $error("fixed line driven while serial off");

	a_tx_drive: assert property (@(posedge mclk) disable iff (rst)
		serial_en.tx_on && async_tx_oe
		|=> !pd_q.oe_n[1] && pd_q.o[1] == $past(async_tx_data))
		else $error("transmit line not driven");

	a_fix_sync_on: assert property (@(posedge mclk) disable iff (rst)
		rd && sel == pfip_pkg::PFIP_SEL_D && serial_en.sync_serial_on
		|=> rdata_q[5:2] == 4'h0)
		else $error("sync serial lines not zero");

	a_fix_line7: assert property (@(posedge mclk) disable iff (rst)
		rd && sel == pfip_pkg::PFIP_SEL_D
		|=> rdata_q[7] == $past(sync_q[3][7]))
		else $error("fixed line 7 not pin level");

	// Lines 0, 6 and 7 are inputs only; nothing may drive them
	a_fix_undriven: assert property (@(posedge mclk) disable iff (rst)
		pd_q.oe_n[0] && pd_q.oe_n[6] && pd_q.oe_n[7])
		else $error("input-only fixed line driven");
endmodule // pfip_ports

// *** verif/pfip_board.sv ***
// Board-level model of the pins around the port block
`timescale 1ns/100ps
module pfip_board (
	input wire pfip_pkg::pfip_pin_t pa_q,
	input wire pfip_pkg::pfip_pin_t pb_q,
	input wire pfip_pkg::pfip_pin_t pc_q,
	input wire pfip_pkg::pfip_pin_t pd_q,
	input wire logic [31:0] ext,
	output logic [7:0] pa_i,
	output logic [7:0] pb_i,
	output logic [7:0] pc_i,
	output logic [7:0] pd_i
);
	// A driven pin shows the block's value, else the board's own level
	assign pa_i = (pa_q.o & ~pa_q.oe_n) | (ext[7:0] & pa_q.oe_n);
	assign pb_i = (pb_q.o & ~pb_q.oe_n) | (ext[15:8] & pb_q.oe_n);
	assign pc_i = (pc_q.o & ~pc_q.oe_n) | (ext[23:16] & pc_q.oe_n);
	assign pd_i = (pd_q.o & ~pd_q.oe_n) | (ext[31:24] & pd_q.oe_n);
endmodule // pfip_board

// *** verif/tb_top.sv ***
// Randomised self-checking bench for the port block
`timescale 1ns/100ps
module tb_top;
	logic mclk = 0, rst = 1, wr_data = 0, wr_dir = 0, rd = 0, tx_oe = 0;
	pfip_pkg::pfip_sel_t sel = pfip_pkg::PFIP_SEL_A;
	pfip_pkg::pfip_serial_t serial_en = 3'h0;
	pfip_pkg::pfip_pin_t pa_q, pb_q, pc_q, pd_q, q;
	logic [7:0] wdata = 8'h00, rdata_q, pa_i, pb_i, pc_i, pd_i, d, l, e;
	logic [31:0] ext = 32'h0;
	logic [3:0] so_d = 4'h0, so_oe = 4'h0, sin_q;
	logic rx_q;
	int error_cnt = 0, comparisons = 0;
	always #12.5 mclk = ~mclk;
	pfip_ports dut (.mclk(mclk), .rst(rst), .sel(sel), .wr_data(wr_data),
		.wr_dir(wr_dir), .rd(rd), .wdata(wdata), .rdata_q(rdata_q),
		.pa_i(pa_i), .pb_i(pb_i), .pc_i(pc_i), .pa_q(pa_q), .pb_q(pb_q),
		.pc_q(pc_q), .fixed_input_lines(pd_i), .serial_en(serial_en),
		.async_tx_data(ext[25]), .async_tx_oe(tx_oe), .sync_out_data(so_d),
		.sync_out_oe(so_oe), .async_rx_line_q(rx_q), .sync_in_q(sin_q),
		.pd_q(pd_q));
	pfip_board board (.pa_q(pa_q), .pb_q(pb_q), .pc_q(pc_q), .pd_q(pd_q),
		.ext(ext), .pa_i(pa_i), .pb_i(pb_i), .pc_i(pc_i), .pd_i(pd_i));
	task automatic chk(input logic [7:0] s, input logic [7:0] x);
		comparisons++;
		if (s !== x) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	// One request held for exactly one edge, then settled outputs
	task automatic op(input int p, input logic [7:0] w, input logic a, b, c);
		@(posedge mclk);
		sel <= pfip_pkg::pfip_sel_t'(p);
		wdata <= w;
		wr_data <= a;
		wr_dir <= b;
		rd <= c;
		@(posedge mclk);
		wr_data <= 0;
		wr_dir <= 0;
		rd <= 0;
		#1;
	endtask
	function automatic logic [7:0] exp_fix(input logic [7:0] v, input logic [2:0] s);
		exp_fix = v & 8'hbf;
		if (s[2] && s[1]) exp_fix[1:0] = 2'h0;
		if (s[0]) exp_fix[5:2] = 4'h0;
	endfunction
	task automatic report_and_stop;
		$display("errors=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#125000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		void'($urandom(36));
		repeat (16) @(posedge mclk);
		rst <= 0;
		for (int p = 0; p < 3; p++) begin
			op(p, 8'h00, 0, 1, 1);
			chk(rdata_q, 8'h00);
		end
		chk(pa_q.oe_n, 8'hff);
		chk(pd_q.oe_n, 8'hff);
		for (int i = 0; i < 40; i++) begin
			for (int p = 0; p < 3; p++) begin
				d = i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'($urandom);
				l = 8'($urandom);
				e = 8'($urandom);
				ext[p*8 +: 8] <= e;
				// Latch written first so the direction write must expose it
				op(p, l, 1, 0, 0);
				op(p, d, 0, 1, 0);
				q = p == 0 ? pa_q : p == 1 ? pb_q : pc_q;
				chk(q.oe_n, ~d);
				chk(q.o & d, l & d);
				op(p, 8'h00, 0, 1, 1);
				chk(rdata_q, d);
				op(p, 8'h00, 0, 0, 1);
				chk(rdata_q, (l & d) | (e & ~d));
			end
			e = 8'($urandom);
			ext[31:24] <= e;
			serial_en <= pfip_pkg::pfip_serial_t'(i[2:0]);
			tx_oe <= 1'($urandom);
			so_d <= 4'($urandom);
			so_oe <= 4'($urandom);
			repeat (3) @(posedge mclk);
			op(3, 8'hff, 1, 0, 1);
			chk(rdata_q, exp_fix(e, 3'(i)));
			chk({7'h0, rx_q}, {7'h0, e[0]});
			if (!i[0]) chk({4'h0, sin_q}, {4'h0, e[5:2]});
		end
		report_and_stop();
	end
endmodule // tb_top
